// [sdli_asserts.sv]
/*
  sdli_asserts: wire-level checks on the link between host and DAC ends.
  Assumes: one clk domain; instanced by the bench beside the link interface.
*/
`timescale 1ns/1ns
module sdli_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link wires
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic selectN,
  input wire logic chainOut
);
  // ==========================================================
  // helper history of the wires
  logic        clkQ_r;
  logic [4:0]  rises_r;
  logic [15:0] hist_r;
  wire         rise = serialClk && !clkQ_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clkQ_r  <= 1'b0;
      rises_r <= 5'h00;
      hist_r  <= 16'h0000;
    end else begin
      clkQ_r <= serialClk;
      if ($fell(selectN)) rises_r <= 5'h00;
      else if (rise && !selectN) rises_r <= rises_r + 5'h01;
      if (rise && !selectN) hist_r <= {hist_r[14:0], serialData};
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence sClkHigh;
    serialClk [*8];
  endsequence
  a_sel_clk_low: assert property ($changed(selectN) |-> !serialClk)
    else $error("select moved while serial clock high");
  a_clk_parked: assert property (selectN |-> !serialClk)
    else $error("serial clock high while deselected");
  a_clk_high_len: assert property ($rose(serialClk) |-> sClkHigh)
    else $error("serial clock high phase too short");
  a_data_held: assert property (serialClk |-> $stable(serialData))
    else $error("serial data moved while clock high");
  a_frame_len: assert property ($rose(selectN) |-> rises_r == 5'h10 || rises_r == 5'h0c)
    else $error("frame length not twelve or sixteen");
  a_sub_zero: assert property ($rose(selectN) |-> hist_r[1:0] == 2'b00)
    else $error("trailing sub bits not zero");
  a_chain_lag: assert property (rise && !selectN |-> chainOut == hist_r[15])
    else $error("chain output not sixteen bits behind");
  a_chain_fall: assert property ($changed(chainOut) |-> !serialClk && !$past(serialClk, 2))
    else $error("chain output moved off a falling edge");
  a_chain_hold: assert property (selectN && $past(selectN, 6) |-> $stable(chainOut))
    else $error("chain output moved while deselected");
endmodule

// [sdli_dac.sv]
/*
  sdli_dac: digital front end of the 10-bit serial DAC.
  Assumes: link wires are asynchronous to clk and slow enough (>=3 clk per half period)
  to be sampled after a two-flop synchroniser.
*/
//
// Contract
// - reset clears the DAC register to zero
// - latch is twelve bits, sub-LSBs zero
// - select low shifts sixteen bits MSB first
// - serial clock rise shifts one bit
// - select rise loads DAC register
// - select high ignores serial clock
// - host moves select only clock low
// - twelve-bit frame allowed uncascaded
// - sixteen-bit frame has four dummies
// - cascade needs sixteen clocks plus edge
// - chain output lags sixteen clocks plus
// - chain output changes on falling edges
// - chain output holds, never floats
// - chain output feeds next data input
// - byte hosts send two bytes
// - word hosts send one write
// - code is straight binary, 512 midscale
// - host parks clock low when deselected
`timescale 1ns/1ns
module sdli_dac (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // link
  sdli_link_if.dac        link,
  // converter side: straight binary code, vout = 2*vref*code/1024
  output logic [9:0]      dacCode,
  output logic [11:0]     dacLatch,
  output logic            dacUpdate
);
  // ==========================================================
  // synchronisers
  logic [1:0] sclkS_r, dataS_r, selS_r;
  logic       sclkD_r, selD_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclkS_r <= 2'b00;
      dataS_r <= 2'b00;
      selS_r  <= 2'b11;
      sclkD_r <= 1'b0;
      selD_r  <= 1'b1;
    end else begin
      sclkS_r <= {sclkS_r[0], link.serialClk};
      dataS_r <= {dataS_r[0], link.serialData};
      selS_r  <= {selS_r[0], link.selectN};
      sclkD_r <= sclkS_r[1];
      selD_r  <= selS_r[1];
    end
  end

  wire sclk    = sclkS_r[1];
  wire sdata   = dataS_r[1];
  wire selN    = selS_r[1];
  wire selLow  = ~selN;
  wire sclkRise = sclk & ~sclkD_r;
  wire sclkFall = ~sclk & sclkD_r;
  wire selRise  = selN & ~selD_r;
  wire doShift  = sclkRise & selLow;
  wire doChain  = sclkFall & selLow;

  // ==========================================================
  // shift, chain and DAC registers
  logic [15:0] shift_r;
  logic        chain_r;
  logic [9:0]  code_r;
  logic [11:0] latch_r;
  logic        upd_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_r <= sdli_pkg::SHIFT_RESET;
    end else if (doShift) begin
      shift_r <= {shift_r[14:0], sdata};
    end
  end

  // the new top bit after each rise comes out on the next fall, one rise before it leaves
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chain_r <= 1'b0;
    end else if (doChain) begin
      chain_r <= shift_r[15];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code_r  <= sdli_pkg::CODE_RESET;
      latch_r <= 12'h000;
      upd_r   <= 1'b0;
    end else begin
      upd_r <= selRise;
      if (selRise) begin
        code_r  <= shift_r[sdli_pkg::CODE_MSB:sdli_pkg::CODE_LSB];
        latch_r <= shift_r[11:0];
      end
    end
  end

  // a driven totem-pole output: no enable, holds while deselected
  assign link.chainOut = chain_r;
  assign dacCode       = code_r;
  assign dacLatch      = latch_r;
  assign dacUpdate     = upd_r;
endmodule

// [sdli_fifo.sv]
/*
  sdli_fifo: synchronous word FIFO with valid/ready on both sides.
  Assumes: single clock, asynchronous active-low reset.
*/
`timescale 1ns/1ns
module sdli_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  wire              doWrite;
  wire              doRead;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign doWrite  = inValid & inReady;
  assign doRead   = outValid & outReady;

  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doWrite) wrPtr_r <= wrPtr_r + 1'b1;
      if (doRead) rdPtr_r <= rdPtr_r + 1'b1;
      count_r <= count_r + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule

// [sdli_host.sv]
/*
  sdli_host: serial master that loads DAC codes from a 16-word FIFO.
  Assumes: the DAC end samples the link wires on its own clock.
*/
`timescale 1ns/1ns
module sdli_host (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // user side: 10-bit codes and frame kind
  input  wire logic                codeValid,
  output logic                     codeReady,
  input  wire logic [9:0]          codeData,
  input  wire logic [1:0]          frameKind,
  output logic                     busy,
  // link
  sdli_link_if.host                link
);
  // ==========================================================
  // queue
  logic       rdy_r;
  wire        qValid;
  logic       qReady;
  wire [11:0] qData;
  wire        inReadyW;

  // a word is taken only while codeReady shows, and codeReady drops for one
  // cycle after each take so that it never shows a stale not-full
  wire        takeCode = codeValid & rdy_r;

  sdli_fifo #(.WIDTH(12), .DEPTH(sdli_pkg::FIFO_DEPTH)) i_sdli_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .inValid  (takeCode),
    .inReady  (inReadyW),
    .inData   ({frameKind, codeData}),
    .outValid (qValid),
    .outReady (qReady),
    .outData  (qData)
  );

  // ==========================================================
  // frame engine
  sdli_pkg::sdli_state_t state_r, state_nxt;
  logic [15:0] shift_r;
  logic [4:0]  bitsLeft_r;
  logic [4:0]  bitsSent_r;
  logic        bytes_r;
  logic [3:0]  div_r;
  logic        sclk_r, data_r, selN_r, busy_r;
  wire         tick   = (div_r == '0);
  wire [1:0]   kind   = qData[11:10];
  // sub-LSB bits forced to zero; upper four are zero dummies
  wire [15:0]  frame  = {4'h0, qData[9:0], 2'b00};
  wire [4:0]   nBits  = (kind == sdli_pkg::SDLI_FRAME_SHORT) ? sdli_pkg::BITS_SHORT
                                                             : sdli_pkg::BITS_FULL;

  always_comb begin
    state_nxt = state_r;
    qReady    = 1'b0;
    case (state_r)
      sdli_pkg::SDLI_IDLE:  if (qValid) begin
        state_nxt = sdli_pkg::SDLI_SETUP;
        qReady    = 1'b1;
      end
      sdli_pkg::SDLI_SETUP: if (tick) state_nxt = sdli_pkg::SDLI_LOW;
      sdli_pkg::SDLI_LOW:   if (tick) state_nxt = sdli_pkg::SDLI_HIGH;
      sdli_pkg::SDLI_HIGH:  if (tick) begin
        if (bitsLeft_r == 5'h01) state_nxt = sdli_pkg::SDLI_END;
        else if (bytes_r && bitsSent_r == sdli_pkg::BITS_BYTE - 5'h01)
          state_nxt = sdli_pkg::SDLI_BGAP;
        else state_nxt = sdli_pkg::SDLI_LOW;
      end
      sdli_pkg::SDLI_BGAP:  if (tick) state_nxt = sdli_pkg::SDLI_LOW;
      sdli_pkg::SDLI_END:   if (tick) state_nxt = sdli_pkg::SDLI_GAP;
      sdli_pkg::SDLI_GAP:   if (tick) state_nxt = sdli_pkg::SDLI_IDLE;
      default:              state_nxt = sdli_pkg::SDLI_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= '0;
    end else if (state_r == sdli_pkg::SDLI_IDLE || tick) begin
      div_r <= sdli_pkg::HALF_CNT;
    end else begin
      div_r <= div_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= sdli_pkg::SDLI_IDLE;
      shift_r    <= sdli_pkg::SHIFT_RESET;
      bitsLeft_r <= '0;
      bitsSent_r <= '0;
      bytes_r    <= 1'b0;
      sclk_r     <= 1'b0;
      data_r     <= 1'b0;
      selN_r     <= 1'b1;
      rdy_r      <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rdy_r   <= inReadyW & ~takeCode;
      busy_r  <= (state_nxt != sdli_pkg::SDLI_IDLE) || qValid;
      case (state_r)
        sdli_pkg::SDLI_IDLE: if (qValid) begin
          // select falls with the clock low, MSB placed ahead of the first rise
          selN_r     <= 1'b0;
          shift_r    <= (nBits == sdli_pkg::BITS_SHORT) ? {frame[11:0], 4'h0} : frame;
          bitsLeft_r <= nBits;
          bitsSent_r <= '0;
          bytes_r    <= (kind == sdli_pkg::SDLI_FRAME_BYTES);
        end
        sdli_pkg::SDLI_SETUP: if (tick) data_r <= shift_r[15];
        sdli_pkg::SDLI_LOW:   if (tick) sclk_r <= 1'b1;
        sdli_pkg::SDLI_HIGH:  if (tick) begin
          sclk_r     <= 1'b0;
          shift_r    <= {shift_r[14:0], 1'b0};
          data_r     <= shift_r[14];
          bitsLeft_r <= bitsLeft_r - 5'h01;
          bitsSent_r <= bitsSent_r + 5'h01;
        end
        // the END half period gives the chain its extra falling edge
        sdli_pkg::SDLI_END:   if (tick) selN_r <= 1'b1;
        sdli_pkg::SDLI_GAP:   sclk_r <= 1'b0;
        default: ;
      endcase
    end
  end

  assign codeReady      = rdy_r;
  assign busy           = busy_r;
  assign link.serialClk  = sclk_r;
  assign link.serialData = data_r;
  assign link.selectN    = selN_r;
endmodule

// [sdli_link_if.sv]
/*
  sdli_link_if: the three wires plus chain output between host and DAC.
  Assumes: both ends run on one clk; all wires are one-way, no enables.
*/
`timescale 1ns/1ns
interface sdli_link_if;
  logic serialClk;
  logic serialData;
  logic selectN;
  logic chainOut;

  modport host (output serialClk, output serialData, output selectN, input chainOut);
  modport dac  (input serialClk, input serialData, input selectN, output chainOut);
endinterface

// [sdli_pkg.sv]
/*
  sdli_pkg: constants shared by both ends of the three-wire DAC load link.
  Assumes: included before the interface and the end modules.
*/
package sdli_pkg;
  // ==========================================================
  // frame layout
  localparam int          SHIFT_W     = 16;
  localparam int          CODE_W      = 10;
  localparam int          LATCH_W     = 12;
  localparam int          CODE_MSB    = 11;
  localparam int          CODE_LSB    = 2;
  localparam int          DUMMY_W     = 4;
  localparam int          SUB_W       = 2;
  localparam logic [9:0]  CODE_RESET  = 10'h000;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [4:0]  BITS_FULL   = 5'h10;
  localparam logic [4:0]  BITS_SHORT  = 5'h0c;
  localparam logic [4:0]  BITS_BYTE   = 5'h08;
  // ==========================================================
  // timing: host serial clock made from clk
  localparam int          CLK_NS      = 8;
  localparam int          SCLK_HALF_NS = 80;
  localparam int          HALF_CYC    = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  HALF_CNT    = 4'(HALF_CYC - 1);
  localparam logic [3:0]  GAP_CNT     = 4'(HALF_CYC - 1);
  localparam int          FIFO_DEPTH  = 16;
  // ==========================================================
  // host frame kinds
  typedef enum logic [1:0] {
    SDLI_FRAME_FULL  = 2'b00,
    SDLI_FRAME_SHORT = 2'b01,
    SDLI_FRAME_BYTES = 2'b10
  } sdli_frame_t;

  typedef enum logic [2:0] {
    SDLI_IDLE   = 3'b000,
    SDLI_SETUP  = 3'b001,
    SDLI_LOW    = 3'b010,
    SDLI_HIGH   = 3'b011,
    SDLI_BGAP   = 3'b100,
    SDLI_END    = 3'b101,
    SDLI_GAP    = 3'b110
  } sdli_state_t;
endpackage

// [serial_dac_load_interface_tb.sv]
/*
  serial_dac_load_interface_tb: host end driving the DAC end over the link.
  Assumes: both ends share clk; the bench drives the host user side only.
*/
`timescale 1ns/1ns
module serial_dac_load_interface_tb;
  // ==========================================================
  // stimulus and observation
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        codeValid = 1'b0;
  logic [9:0]  codeData = 10'h000;
  logic [1:0]  frameKind = 2'h0;
  logic        codeReady, busy, dacUpdate;
  logic [9:0]  dacCode;
  logic [11:0] dacLatch;
  logic [15:0] cap, chCap, histAt;
  logic [15:0] hist = 16'h0000;
  logic        sawFull = 1'b0;
  logic [11:0] sent[$];
  logic [9:0]  want[$];
  logic [21:0] got[$];
  int          n_fail = 0, checks = 0, nBits = 0, cyc = 0, waitRun = 0;
  sdli_link_if lk();
  sdli_host i_sdli_host (.clk(clk), .resetn(resetn), .codeValid(codeValid),
    .codeReady(codeReady), .codeData(codeData), .frameKind(frameKind), .busy(busy), .link(lk));
  sdli_dac i_sdli_dac (.clk(clk), .resetn(resetn), .link(lk), .dacCode(dacCode),
    .dacLatch(dacLatch), .dacUpdate(dacUpdate));
  sdli_asserts i_sdli_asserts (.clk(clk), .resetn(resetn), .serialClk(lk.serialClk),
    .serialData(lk.serialData), .selectN(lk.selectN), .chainOut(lk.chainOut));
  always #4 clk = ~clk;
  // ==========================================================
  // comparison and verdict
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // wire monitors: bits as the DAC end should see them
  always @(negedge lk.selectN) begin
    nBits = 0;
    histAt = hist;
  end
  always @(posedge lk.serialClk) if (lk.selectN === 1'b0) begin
    chCap = {chCap[14:0], lk.chainOut};
    cap = {cap[14:0], lk.serialData};
    hist = {hist[14:0], lk.serialData};
    nBits++;
  end
  always @(posedge lk.selectN) if (resetn === 1'b1 && sent.size() > 0) begin : frm
    logic [11:0] s;
    s = sent.pop_front();
    chk("bit count", 16'(nBits), (s[11:10] == 2'h1) ? 16'h000c : 16'h0010);
    chk("frame bits", (s[11:10] == 2'h1) ? {4'h0, cap[11:0]} : cap, {4'h0, s[9:0], 2'b00});
    if (nBits == 16) chk("chain bits", chCap, histAt);
  end
  // ready drops one cycle after every take; only a long wait means a full queue
  always @(negedge clk) begin
    if (resetn && codeValid && codeReady === 1'b0) waitRun++;
    else waitRun = 0;
    if (waitRun > 4) sawFull = 1'b1;
  end
  // loads seen, and the run ceiling (23 frames need about 7500 cycles)
  always @(posedge clk) begin
    if (dacUpdate === 1'b1) got.push_back({dacCode, dacLatch});
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  // ==========================================================
  // user-side driving; codeValid stays up between back-to-back pushes
  task automatic push(input logic [1:0] k, input logic [9:0] c);
    int i;
    @(negedge clk);
    codeValid = 1'b1;
    codeData = c;
    frameKind = k;
    for (i = 0; i < 5000 && codeReady !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    sent.push_back({k, c});
    want.push_back(c);
  endtask
  task automatic drain;
    int i;
    logic [21:0] g;
    @(negedge clk);
    codeValid = 1'b0;
    for (i = 0; i < 20000 && !(busy === 1'b0 && got.size() == want.size()); i++) @(negedge clk);
    chk("loads", 16'(got.size()), 16'(want.size()));
    while (got.size() > 0 && want.size() > 0) begin
      g = got.pop_front();
      chk("code", 16'(g[21:12]), 16'(want[0]));
      chk("latch", 16'(g[11:0]), {4'h0, want.pop_front(), 2'b00});
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    @(negedge clk);
    chk("code", 16'(dacCode), 16'h0000);
    chk("latch", 16'(dacLatch), 16'h0000);
    chk("idle clock", 16'(lk.serialClk), 16'h0000);
    chk("chain", 16'(lk.chainOut), 16'h0000);
  endtask
  // every frame kind, full scale, midscale, one, zero, back to back
  task automatic t_kinds;
    push(2'h0, 10'h3ff);
    push(2'h1, 10'h200);
    push(2'h2, 10'h001);
    push(2'h1, 10'h000);
    push(2'h0, 10'h2aa);
    drain();
  endtask
  // eighteen words: one goes straight to the link, sixteen fill the queue
  task automatic t_fill;
    int i;
    for (i = 0; i < 18; i++) push(2'(i % 3), 10'(i * 73 + 5));
    chk("queue refused", 16'(sawFull), 16'h0001);
    drain();
  endtask
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_kinds();
    t_fill();
    stop_test();
  end
endmodule
